// ---- src/flc_consts.svh ----
// offsets, command codes and timing counts of the flash command controller
`ifndef FLC_CONSTS_SVH
`define FLC_CONSTS_SVH

`define FLC_AW          23
`define FLC_BUF_DEPTH   32
`define FLC_CLK_MHZ     250
`define FLC_T_WP_NS     35
`define FLC_T_WPH_NS    20
`define FLC_T_ACC_NS    90
`define FLC_SYNC_CYC    2
`define FLC_WP_CYC      ((`FLC_T_WP_NS * `FLC_CLK_MHZ + 999) / 1000)
`define FLC_REC_CYC     ((`FLC_T_WPH_NS * `FLC_CLK_MHZ + 999) / 1000)
`define FLC_RD_CYC      ((`FLC_T_ACC_NS * `FLC_CLK_MHZ + 999) / 1000 + `FLC_SYNC_CYC)

`define FLC_REG_CTRL    8'h00
`define FLC_REG_ADDR    8'h04
`define FLC_REG_WDATA   8'h08
`define FLC_REG_COUNT   8'h0c
`define FLC_REG_STATUS  8'h10
`define FLC_REG_RDATA   8'h14
`define FLC_REG_BUF     8'h80

`define FLC_STAT_BUSY   0
`define FLC_STAT_DONE   1
`define FLC_STAT_FAIL   2
`define FLC_STAT_RB     3
`define FLC_STAT_SUSP   4

`define FLC_OP_READ     4'h0
`define FLC_OP_RESET    4'h1
`define FLC_OP_AUTOSEL  4'h2
`define FLC_OP_CFI      4'h3
`define FLC_OP_ENSEC    4'h4
`define FLC_OP_EXSEC    4'h5
`define FLC_OP_PROG     4'h6
`define FLC_OP_WRBUF    4'h7
`define FLC_OP_ABORT    4'h8
`define FLC_OP_CHIP     4'h9
`define FLC_OP_SECT     4'ha
`define FLC_OP_SUSP     4'hb
`define FLC_OP_RESUME   4'hc

`define FLC_A_UNLOCK1   23'h000aaa
`define FLC_A_UNLOCK2   23'h000555
`define FLC_A_CFI       23'h0000aa
`define FLC_D_UNLOCK1   8'haa
`define FLC_D_UNLOCK2   8'h55
`define FLC_D_RESET     8'hf0
`define FLC_D_AUTOSEL   8'h90
`define FLC_D_CFI       8'h98
`define FLC_D_ENSEC     8'h88
`define FLC_D_EXSEC     8'h00
`define FLC_D_PROG      8'ha0
`define FLC_D_WRBUF     8'h25
`define FLC_D_BUF2FL    8'h29
`define FLC_D_ERASE     8'h80
`define FLC_D_CHIP      8'h10
`define FLC_D_SECT      8'h30
`define FLC_D_SUSP      8'hb0
`define FLC_D_RESUME    8'h30

`endif

// ---- src/flc_pkg.sv ----
// types of the flash command controller
`include "flc_consts.svh"
package flc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ISSUE = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_FIN   = 4'b1000
    } flc_state_t;
    typedef enum logic [3:0] {
        EC_IDLE  = 4'b0001,
        EC_SETUP = 4'b0010,
        EC_PULSE = 4'b0100,
        EC_RECOV = 4'b1000
    } flc_cyc_state_t;
    typedef enum logic [2:0] {K_END, K_WR, K_RD, K_BUF, K_POLL} flc_kind_t;
    typedef enum logic [1:0] {AS_UNLOCK1, AS_UNLOCK2, AS_CFI, AS_USER} flc_asel_t;
    typedef enum logic [1:0] {DS_CONST, DS_USER, DS_COUNT} flc_dsel_t;
    typedef struct packed {
        flc_kind_t  kind;
        flc_asel_t  asel;
        flc_dsel_t  dsel;
        logic [7:0] data;
    } flc_step_t;
endpackage

// ---- src/flc_cyc_if.sv ----
// one flash bus cycle request and answer between sequencer and pin engine
`timescale 1ns/1ps
`include "flc_consts.svh"
interface flc_cyc_if;
    logic                req;
    logic                wr;
    logic [`FLC_AW-1:0]  addr;
    logic [7:0]          wdata;
    logic                done;
    logic [7:0]          rdata;
    modport ctl (output req, wr, addr, wdata, input done, rdata);
    modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// ---- src/flc_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module flc_sync #(
    parameter int W = 9
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // pins in, synced out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ---- src/flc_pin_cycle.sv ----
// pin engine: drives one timed write or read cycle on the flash strobes
`timescale 1ns/1ps
`include "flc_consts.svh"
module flc_pin_cycle (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    // request from sequencer
    flc_cyc_if.eng                  cyc,
    // synced data pins
    input  wire logic [7:0]         dq_sync,
    // flash pins
    output logic      [`FLC_AW-1:0] fa,
    output logic      [7:0]         dq_o,
    output logic                    dq_oe,
    output logic                    ce_n,
    output logic                    we_n,
    output logic                    oe_n
);
    import flc_pkg::*;

    flc_cyc_state_t state;
    logic [5:0]     cnt;
    logic           wr_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state     <= EC_IDLE;
            cnt       <= 6'h00;
            wr_q      <= 1'b0;
            fa        <= '0;
            dq_o      <= 8'h00;
            dq_oe     <= 1'b0;
            ce_n      <= 1'b1;
            we_n      <= 1'b1;
            oe_n      <= 1'b1;
            cyc.done  <= 1'b0;
            cyc.rdata <= 8'h00;
        end else begin
            cyc.done <= 1'b0;
            case (state)
                EC_IDLE: begin
                    if (cyc.req) begin
                        // address settles before either strobe falls
                        fa    <= cyc.addr;
                        dq_o  <= cyc.wdata;
                        dq_oe <= cyc.wr;
                        wr_q  <= cyc.wr;
                        state <= EC_SETUP;
                    end
                end
                EC_SETUP: begin
                    ce_n  <= 1'b0;
                    we_n  <= ~wr_q;
                    oe_n  <= wr_q;
                    cnt   <= wr_q ? 6'(`FLC_WP_CYC - 1) : 6'(`FLC_RD_CYC - 1);
                    state <= EC_PULSE;
                end
                EC_PULSE: begin
                    if (cnt == 6'h00) begin
                        ce_n  <= 1'b1;
                        we_n  <= 1'b1;
                        oe_n  <= 1'b1;
                        if (!wr_q) begin
                            cyc.rdata <= dq_sync;
                        end
                        cnt   <= 6'(`FLC_REC_CYC - 1);
                        state <= EC_RECOV;
                    end else begin
                        cnt <= cnt - 6'h01;
                    end
                end
                EC_RECOV: begin
                    // data held past the rising strobe edge
                    if (cnt == 6'h00) begin
                        dq_oe    <= 1'b0;
                        cyc.done <= 1'b1;
                        state    <= EC_IDLE;
                    end else begin
                        cnt <= cnt - 6'h01;
                    end
                end
                default: state <= EC_IDLE;
            endcase
        end
    end
endmodule

// ---- src/flc_ctrl.sv ----
// flash command controller: AHB-Lite registers, command sequencer, status polling
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "flc_consts.svh"
module flc_ctrl (
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               NRST,
    // AHB-Lite slave
    input  wire logic               HSEL,
    input  wire logic [31:0]        HADDR,
    input  wire logic [1:0]         HTRANS,
    input  wire logic               HWRITE,
    input  wire logic [2:0]         HSIZE,
    input  wire logic               HREADY,
    input  wire logic [31:0]        HWDATA,
    output logic      [31:0]        HRDATA,
    output logic                    HREADYOUT,
    output logic                    HRESP,
    // flash pins
    output logic      [`FLC_AW-1:0] FA,
    input  wire logic [7:0]         FDQ_I,
    output logic      [7:0]         FDQ_O,
    output logic                    FDQ_OE,
    output logic                    FCE_N,
    output logic                    FWE_N,
    output logic                    FOE_N,
    input  wire logic               READY_BUSY_N
);
    import flc_pkg::*;

    flc_cyc_if cyc ();

    flc_state_t         state;
    logic [3:0]         op;
    logic [`FLC_AW-1:0] addr;
    logic [7:0]         wdata;
    logic [4:0]         count;
    logic [7:0]         buffer [0:`FLC_BUF_DEPTH-1];
    logic [7:0]         rdata;
    logic               done;
    logic               fail;
    logic               suspended;
    logic               susp_req;
    logic [2:0]         idx;
    logic [4:0]         bidx;
    logic [1:0]         pphase;
    logic               susp_wr;
    flc_kind_t          cur_kind;
    flc_step_t          st;
    logic [7:0]         dq_sync;
    logic               rb_sync;
    logic               dp_valid;
    logic               dp_write;
    logic [7:0]         dp_addr;
    logic               wr_en;
    logic               start;
    logic               poll_ok;

    flc_sync #(.W(9)) u_sync (
        .clk  (CLK),
        .nrst (NRST),
        .din  ({READY_BUSY_N, FDQ_I}),
        .dout ({rb_sync, dq_sync})
    );

    flc_pin_cycle u_pin (
        .clk     (CLK),
        .nrst    (NRST),
        .cyc     (cyc.eng),
        .dq_sync (dq_sync),
        .fa      (FA),
        .dq_o    (FDQ_O),
        .dq_oe   (FDQ_OE),
        .ce_n    (FCE_N),
        .we_n    (FWE_N),
        .oe_n    (FOE_N)
    );

    // command table: one bus cycle per step index, except buffer and poll steps, which repeat their cycle
    function automatic flc_step_t seq_step(input logic [3:0] o, input logic [2:0] i);
        flc_step_t s;
        logic      unl;
        s   = '{K_END, AS_USER, DS_CONST, 8'h00};
        unl = (o == `FLC_OP_AUTOSEL) || (o == `FLC_OP_ENSEC) || (o == `FLC_OP_EXSEC)
            || (o == `FLC_OP_PROG) || (o == `FLC_OP_WRBUF) || (o == `FLC_OP_ABORT)
            || (o == `FLC_OP_CHIP) || (o == `FLC_OP_SECT);
        if (unl && i == 3'd0) begin
            s = '{K_WR, AS_UNLOCK1, DS_CONST, `FLC_D_UNLOCK1};
        end else if (unl && i == 3'd1) begin
            s = '{K_WR, AS_UNLOCK2, DS_CONST, `FLC_D_UNLOCK2};
        end else begin
            case (o)
                `FLC_OP_READ:   if (i == 3'd0) s = '{K_RD, AS_USER, DS_CONST, 8'h00};
                `FLC_OP_RESET:  if (i == 3'd0) s = '{K_WR, AS_USER, DS_CONST, `FLC_D_RESET};
                `FLC_OP_CFI:    if (i == 3'd0) s = '{K_WR, AS_CFI, DS_CONST, `FLC_D_CFI};
                `FLC_OP_SUSP:   if (i == 3'd0) s = '{K_WR, AS_USER, DS_CONST, `FLC_D_SUSP};
                `FLC_OP_RESUME: if (i == 3'd0) s = '{K_WR, AS_USER, DS_CONST, `FLC_D_RESUME};
                `FLC_OP_AUTOSEL: begin
                    if (i == 3'd2) s = '{K_WR, AS_UNLOCK1, DS_CONST, `FLC_D_AUTOSEL};
                    if (i == 3'd3) s = '{K_RD, AS_USER, DS_CONST, 8'h00};
                end
                `FLC_OP_ENSEC:  if (i == 3'd2) s = '{K_WR, AS_UNLOCK1, DS_CONST, `FLC_D_ENSEC};
                `FLC_OP_EXSEC: begin
                    if (i == 3'd2) s = '{K_WR, AS_UNLOCK1, DS_CONST, `FLC_D_AUTOSEL};
                    if (i == 3'd3) s = '{K_WR, AS_USER, DS_CONST, `FLC_D_EXSEC};
                end
                `FLC_OP_ABORT:  if (i == 3'd2) s = '{K_WR, AS_UNLOCK1, DS_CONST, `FLC_D_RESET};
                `FLC_OP_PROG: begin
                    if (i == 3'd2) s = '{K_WR, AS_UNLOCK1, DS_CONST, `FLC_D_PROG};
                    if (i == 3'd3) s = '{K_WR, AS_USER, DS_USER, 8'h00};
                    if (i == 3'd4) s = '{K_POLL, AS_USER, DS_CONST, 8'h00};
                end
                `FLC_OP_WRBUF: begin
                    if (i == 3'd2) s = '{K_WR, AS_USER, DS_CONST, `FLC_D_WRBUF};
                    if (i == 3'd3) s = '{K_WR, AS_USER, DS_COUNT, 8'h00};
                    if (i == 3'd4) s = '{K_BUF, AS_USER, DS_CONST, 8'h00};
                    if (i == 3'd5) s = '{K_WR, AS_USER, DS_CONST, `FLC_D_BUF2FL};
                    if (i == 3'd6) s = '{K_POLL, AS_USER, DS_CONST, 8'h00};
                end
                `FLC_OP_CHIP, `FLC_OP_SECT: begin
                    if (i == 3'd2) s = '{K_WR, AS_UNLOCK1, DS_CONST, `FLC_D_ERASE};
                    if (i == 3'd3) s = '{K_WR, AS_UNLOCK1, DS_CONST, `FLC_D_UNLOCK1};
                    if (i == 3'd4) s = '{K_WR, AS_UNLOCK2, DS_CONST, `FLC_D_UNLOCK2};
                    if (i == 3'd5 && o == `FLC_OP_CHIP) begin
                        s = '{K_WR, AS_UNLOCK1, DS_CONST, `FLC_D_CHIP};
                    end
                    if (i == 3'd5 && o == `FLC_OP_SECT) begin
                        s = '{K_WR, AS_USER, DS_CONST, `FLC_D_SECT};
                    end
                    if (i == 3'd6) s = '{K_POLL, AS_USER, DS_CONST, 8'h00};
                end
                default: s = '{K_END, AS_USER, DS_CONST, 8'h00};
            endcase
        end
        return s;
    endfunction

    function automatic logic [`FLC_AW-1:0] addr_plus(input logic [`FLC_AW-1:0] a,
                                                      input logic [4:0] n);
        return a + {{(`FLC_AW-5){1'b0}}, n};
    endfunction

    assign st = seq_step(op, idx);

    // polled bit: bit 7 of the last byte written, or 1 for erase
    always_comb begin
        if (op == `FLC_OP_PROG) begin
            poll_ok = cyc.rdata[7] == wdata[7];
        end else if (op == `FLC_OP_WRBUF) begin
            poll_ok = cyc.rdata[7] == buffer[count][7];
        end else begin
            poll_ok = cyc.rdata[7];
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign wr_en     = dp_valid && dp_write;
    assign start     = wr_en && dp_addr == `FLC_REG_CTRL && state == ST_IDLE
                       && (HWDATA[3:0] != `FLC_OP_RESUME || suspended)
                       && (HWDATA[3:0] != `FLC_OP_SUSP);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
            HRDATA   <= 32'h0000_0000;
        end else if (HREADY) begin
            dp_valid <= HSEL && HTRANS[1];
            dp_write <= HWRITE;
            dp_addr  <= HADDR[7:0];
            HRDATA   <= 32'h0000_0000;
            if (HSEL && HTRANS[1] && !HWRITE) begin
                if (HADDR[7:0] == `FLC_REG_CTRL) begin
                    HRDATA <= {28'h0, op};
                end else if (HADDR[7:0] == `FLC_REG_ADDR) begin
                    HRDATA <= {{(32-`FLC_AW){1'b0}}, addr};
                end else if (HADDR[7:0] == `FLC_REG_WDATA) begin
                    HRDATA <= {24'h0, wdata};
                end else if (HADDR[7:0] == `FLC_REG_COUNT) begin
                    HRDATA <= {27'h0, count};
                end else if (HADDR[7:0] == `FLC_REG_STATUS) begin
                    // rb bit mirrors ready_busy_n
                    HRDATA <= {27'h0, suspended, rb_sync, fail, done, state != ST_IDLE};
                end else if (HADDR[7:0] == `FLC_REG_RDATA) begin
                    HRDATA <= {24'h0, rdata};
                end else if (HADDR[7] && HADDR[1:0] == 2'b00) begin
                    HRDATA <= {24'h0, buffer[HADDR[6:2]]};
                end
            end
        end
    end

    // software-written configuration
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            addr  <= '0;
            wdata <= 8'h00;
            count <= 5'h00;
        end else if (wr_en) begin
            if (dp_addr == `FLC_REG_ADDR) begin
                addr <= HWDATA[`FLC_AW-1:0];
            end else if (dp_addr == `FLC_REG_WDATA) begin
                wdata <= HWDATA[7:0];
            end else if (dp_addr == `FLC_REG_COUNT) begin
                count <= HWDATA[4:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_en && dp_addr[7] && dp_addr[1:0] == 2'b00) begin
            buffer[dp_addr[6:2]] <= HWDATA[7:0];
        end
    end

    // suspend request is honoured only while a sector erase polls
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            susp_req <= 1'b0;
        end else if (state == ST_IDLE) begin
            susp_req <= 1'b0;
        end else if (wr_en && dp_addr == `FLC_REG_CTRL && HWDATA[3:0] == `FLC_OP_SUSP
                     && op == `FLC_OP_SECT) begin
            susp_req <= 1'b1;
        end
    end

    // cycle request to pin engine
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cyc.req   <= 1'b0;
            cyc.wr    <= 1'b0;
            cyc.addr  <= '0;
            cyc.wdata <= 8'h00;
        end else begin
            cyc.req <= 1'b0;
            if (state == ST_ISSUE && st.kind != K_END) begin
                cyc.req   <= 1'b1;
                cyc.wr    <= st.kind == K_WR || st.kind == K_BUF
                             || (st.kind == K_POLL && susp_req);
                cyc.wdata <= st.dsel == DS_USER ? wdata
                           : st.dsel == DS_COUNT ? {3'h0, count} : st.data;
                if (st.asel == AS_UNLOCK1) begin
                    cyc.addr <= `FLC_A_UNLOCK1;
                end else if (st.asel == AS_UNLOCK2) begin
                    cyc.addr <= `FLC_A_UNLOCK2;
                end else if (st.asel == AS_CFI) begin
                    cyc.addr <= `FLC_A_CFI;
                end else begin
                    cyc.addr <= addr;
                end
                if (st.kind == K_BUF) begin
                    cyc.addr  <= addr_plus(addr, bidx);
                    cyc.wdata <= buffer[bidx];
                end
                if (st.kind == K_POLL && op == `FLC_OP_WRBUF) begin
                    cyc.addr <= addr_plus(addr, count);
                end
                if (st.kind == K_POLL && susp_req) begin
                    cyc.wdata <= `FLC_D_SUSP;
                end
            end
        end
    end

    // sequencer; only whole sequences go out, so none is left broken
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state     <= ST_IDLE;
            op        <= `FLC_OP_READ;
            idx       <= 3'd0;
            bidx      <= 5'h00;
            pphase    <= 2'd0;
            susp_wr   <= 1'b0;
            cur_kind  <= K_END;
            rdata     <= 8'h00;
            done      <= 1'b0;
            fail      <= 1'b0;
            suspended <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        op     <= HWDATA[3:0];
                        idx    <= 3'd0;
                        bidx   <= 5'h00;
                        pphase <= 2'd0;
                        done   <= 1'b0;
                        fail   <= 1'b0;
                        state  <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    cur_kind <= st.kind;
                    susp_wr  <= st.kind == K_POLL && susp_req;
                    state    <= st.kind == K_END ? ST_FIN : ST_WAIT;
                end
                ST_WAIT: begin
                    if (cyc.done) begin
                        state <= ST_ISSUE;
                        case (cur_kind)
                            K_RD: begin
                                rdata <= cyc.rdata;
                                idx   <= idx + 3'd1;
                            end
                            K_BUF: begin
                                bidx <= bidx + 5'h01;
                                if (bidx == count) begin
                                    idx <= idx + 3'd1;
                                end
                            end
                            K_POLL: begin
                                rdata <= cyc.rdata;
                                if (susp_wr) begin
                                    suspended <= 1'b1;
                                    state     <= ST_FIN;
                                end else if (pphase == 2'd1) begin
                                    state <= ST_FIN;
                                end else if (poll_ok) begin
                                    pphase <= 2'd1;
                                end else if (pphase == 2'd2) begin
                                    fail  <= 1'b1;
                                    state <= ST_FIN;
                                end else if (cyc.rdata[5]) begin
                                    pphase <= 2'd2;
                                end
                            end
                            default: idx <= idx + 3'd1;
                        endcase
                    end
                end
                ST_FIN: begin
                    done  <= 1'b1;
                    state <= ST_IDLE;
                    if (!susp_wr && (op == `FLC_OP_RESUME || op == `FLC_OP_CHIP
                        || op == `FLC_OP_SECT)) begin
                        suspended <= 1'b0; // reset and suspend keep it
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// ---- dv/flc_ctrl_monitor.sv ----
// port assertions of the flash command controller
`timescale 1ns/1ps
module flc_mon (
    // clock, reset and bus answer
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // flash pins
    input wire logic        FDQ_OE,
    input wire logic        FCE_N,
    input wire logic        FWE_N,
    input wire logic        FOE_N,
    input wire logic [22:0] FA,
    input wire logic [7:0]  FDQ_O
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus answer");
    a_strobe_excl: assert property (!(!FWE_N && !FOE_N)) else $error("we oe");
    a_we_with_ce: assert property (!FWE_N |-> !FCE_N) else $error("we ce");
    a_write_driven: assert property (!FWE_N |-> FDQ_OE) else $error("dq off");
    a_read_released: assert property (!FOE_N |-> !FDQ_OE) else $error("dq on");
    a_pulse_width: assert property ($fell(FWE_N) |-> !FWE_N[*8]) else $error("we short");
    a_addr_held: assert property (
        !FWE_N && $past(!FWE_N) |-> $stable(FA) && $stable(FDQ_O)) else $error("moved");
    a_hold_after: assert property (
        $rose(FWE_N) |=> FDQ_OE && $stable(FA)) else $error("hold");
endmodule
bind flc_ctrl flc_mon flc_mon_i (.*);

// ---- dv/flc_flash_model.sv ----
// behavioural byte-wide flash device on the pins
`timescale 1ns/1ps
module flc_flash_model (
    input wire logic [22:0] FA,
    input wire logic [7:0]  FDQ_O,
    input wire logic        FDQ_OE, FCE_N, FWE_N, FOE_N,
    output logic     [7:0]  FDQ_I,
    output logic            READY_BUSY_N
);
    logic [7:0]  mem [int];
    logic [22:0] pa;
    logic [7:0]  pd;
    logic        lo = 0;
    int          st = 0;
    logic        asel = 0, arm = 0, ers = 0, sus = 0;
    logic [7:0]  esa;
    initial READY_BUSY_N = 1;
    initial FDQ_I = 0;
    function automatic logic [7:0] rv();
        if (asel)
            return FA[7:0] == 8'h06 ? 8'h18 : {7'h0, FA[22:15] == 8'h01};
        if (ers && FA[22:15] == esa)
            return {sus, 7'h0};
        if (!READY_BUSY_N && FA == pa)
            return {~pd[7], 7'h0};
        return mem.exists(FA) ? mem[FA] : FA[7:0] ^ 8'h5a;
    endfunction
    always @(negedge FWE_N or negedge FCE_N) if (!FWE_N && !FCE_N) begin
        lo = 1;
        pa = FA;
    end
    always @(posedge FWE_N or posedge FCE_N) if (lo) begin
        lo = 0;
        if (st == 3) begin
            pd = FDQ_O;
            mem[pa] = pd;
            st = 0;
            READY_BUSY_N = 0;
            READY_BUSY_N <= #2000 1'b1;
        end
        else if (st == 2 && arm && FDQ_O == 8'h30) begin
            arm = 0;
            ers = 1;
            esa = pa[22:15];
            st = 0;
            READY_BUSY_N = 0;
        end
        else if (FDQ_O == 8'hf0) begin
            asel = 0;
            st = 0;
        end
        else if (st == 0 && (ers && FDQ_O == 8'hb0 || sus && FDQ_O == 8'h30)) begin
            sus = FDQ_O == 8'hb0;
            READY_BUSY_N = sus;
        end
        else if (st == 0 && pa[11:0] == 12'haaa && FDQ_O == 8'haa) st = 1;
        else if (st == 1 && pa[11:0] == 12'h555 && FDQ_O == 8'h55) st = 2;
        else if (st == 2 && pa[11:0] == 12'haaa && FDQ_O == 8'ha0) st = 3;
        else if (st == 2 && pa[11:0] == 12'haaa && (FDQ_O == 8'h90 || FDQ_O == 8'h80)) begin
            asel = FDQ_O == 8'h90;
            arm = FDQ_O == 8'h80;
            st = 0;
        end
        else st = 0;
    end
    always @(FOE_N, FCE_N, FA, FDQ_OE, FDQ_O, READY_BUSY_N)
        FDQ_I = FDQ_OE ? FDQ_O : (!FOE_N && !FCE_N) ? rv() : ~FDQ_I;
endmodule

// ---- dv/testbench.sv ----
// self-checking bench of the flash command controller
`timescale 1ns/1ps
module testbench;
    logic        CLK = 0, NRST = 0, HSEL = 1, HWRITE = 0;
    logic [1:0]  HTRANS = 0;
    logic [2:0]  HSIZE = 3'h2;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, r;
    logic        HREADYOUT, HRESP, FDQ_OE, FCE_N, FWE_N, FOE_N, READY_BUSY_N;
    logic [22:0] FA;
    logic [7:0]  FDQ_I, FDQ_O;
    wire         HREADY = HREADYOUT;
    int          mismatches = 0, cmp_count = 0;
    always #2 CLK = ~CLK;
    flc_ctrl flc_ctrl_i (.*);
    flc_flash_model flc_flash_model_i (.*);
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rdy();
        int n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 64);
        if (n >= 64) begin
            mismatches++;
            complete_run();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HTRANS <= 2'b10;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        rdy();
        HTRANS <= 2'b00;
        HWDATA <= d;
        rdy();
        r = HRDATA;
    endtask
    task automatic wait_done();
        int n;
        for (n = 0; n < 1000; n++) begin
            bus(0, 8'h10, 0);
            if (r[1] === 1'b1) break;
        end
        if (n == 1000) begin
            mismatches++;
            complete_run();
        end
    endtask
    task automatic sc_refuse();
        bus(1, 8'h00, 32'hc);
        bus(0, 8'h10, 0);
        chk("resume idle", r[0], 1'b0);
        bus(1, 8'h00, 32'hb);
        bus(0, 8'h10, 0);
        chk("suspend idle", r[0], 1'b0);
        bus(1, 8'h40, 32'h1);
        bus(0, 8'h40, 0);
        chk("unmapped", r, 32'h0);
    endtask
    task automatic run_op(input logic [31:0] a, input logic [3:0] o);
        bus(1, 8'h04, a);
        bus(1, 8'h00, {28'h0, o});
        wait_done();
        bus(0, 8'h14, 0);
    endtask
    task automatic sc_read();
        run_op(32'h7ff123, 4'h0);
        chk("array read", r, 32'h79);
    endtask
    task automatic sc_auto();
        run_op(32'h8004, 4'h2);
        chk("protect verify", r, 32'h01);
        run_op(32'h6, 4'h2);
        chk("secured code", r, 32'h18);
        run_op(32'h6, 4'h1);
        run_op(32'h6, 4'h0);
        chk("read after reset", r, 32'h5c);
    endtask
    task automatic sc_erase();
        bus(1, 8'h04, 32'h8000);
        bus(1, 8'h00, 32'ha);
        repeat (200) @(posedge CLK);
        bus(1, 8'h00, 32'hb);
        wait_done();
        chk("suspended", r[4:0], 5'h1a);
        bus(1, 8'h00, 32'hc);
        wait_done();
        chk("resumed", r[4:0], 5'h02);
    endtask
    task automatic sc_prog();
        bus(1, 8'h04, 32'h300);
        bus(1, 8'h08, 32'h3c);
        bus(1, 8'h00, 32'h6);
        repeat (150) @(posedge CLK);
        bus(0, 8'h10, 0);
        chk("busy status", r[3:0], 4'h1);
        wait_done();
        chk("done status", r[3:0], 4'ha);
        bus(0, 8'h14, 0);
        chk("program data", r, 32'h3c);
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        NRST <= 1;
        @(posedge CLK);
        sc_refuse();
        sc_read();
        sc_prog();
        sc_auto();
        sc_erase();
        complete_run();
    end
endmodule
